// ### common/pms_pkg.sv
// Package holding register map, field layout, reset values and states of the power-mode sequencer.
package pms_pkg;

   // Register indices on the plain register port (byte address = 4 x index).
   localparam logic [3:0] REG_PLL_CONTROL_REG   = 4'h0;
   localparam logic [3:0] REG_REGULATOR_CONTROL_REG    = 4'h1;
   localparam logic [3:0] REG_WAKE_MASK = 4'h2;
   localparam logic [3:0] REG_MODE_REQ  = 4'h3;
   localparam logic [3:0] REG_STATUS    = 4'h4;

   // pll_control_reg fields.
   localparam int PLL_BYPASS_BIT  = 8;
   localparam int PLL_DISABLE_BIT = 0;
   localparam logic [15:0] PLL_CONTROL_REG_RESET = 16'h0000;

   // regulator_control_reg fields.
   localparam int VR_FIELD_A_LSB   = 0;
   localparam int VR_GAIN_LSB      = 2;
   localparam int VR_LEVEL_LSB     = 4;
   localparam int VR_CAN_WAKE_BIT  = 8;
   localparam int VR_GPW_WAKE_BIT  = 9;
   localparam int VR_RTC_WAKE_BIT  = 10;
   localparam int VR_BYPASS_BIT    = 12;
   localparam int VR_CKELOW_BIT    = 15;
   localparam logic [1:0]  VR_FIELD_A_OFF = 2'h0;
   localparam logic [15:0] REGULATOR_CONTROL_REG_RESET   = 16'h40B3;
   localparam logic [3:0]  VR_LEVEL_RESET = 4'hB;

   // Regulator level step and base, in millivolts.
   localparam int VR_STEP_MV = 50;
   localparam int VR_BASE_MV = 700;

   // Mode request codes written to the request register.
   localparam logic [1:0] REQ_SLEEP      = 2'h1;
   localparam logic [1:0] REQ_DEEP_SLEEP = 2'h2;

   // Reset sequence length after a hibernate wake, and PLL relock time.
   localparam int RESET_SEQ_CYCLES = 16;
   localparam int PLL_LOCK_CYCLES  = 8;
   localparam int WAKE_BITS        = 8;

   typedef enum logic [5:0] {
      ST_RESET      = 6'h01,
      ST_FULL_ON    = 6'h02,
      ST_ACTIVE     = 6'h04,
      ST_SLEEP      = 6'h08,
      ST_DEEP_SLEEP = 6'h10,
      ST_HIBERNATE  = 6'h20
   } pms_state_t;

endpackage

// ### hw/pms_sync.sv
// Two-flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module pms_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // Levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule

// ### hw/pms_sequencer.sv
// Power-mode sequencer: state machine, clock gates, regulator control and wake paths.
//
// Behaviour
// [R01] Power-up enters full-on, PLL on, clocks running.
// [R02] Active mode bypasses PLL, clocks at input.
// [R03] PLL re-enable needed before full-on or sleep.
// [R04] Active mode keeps DMA to L1 allowed.
// [R05] Sleep stops only core clock domain.
// [R06] Sleep withholds system DMA to L1.
// [R07] Masked wake in sleep picks mode by bypass.
// [R08] Deep sleep stops both clock domains.
// [R09] Deep sleep exits by RTC or reset.
// [R10] Field A 00 enters hibernate, supply off.
// [R11] Hibernate tri-states all external pins.
// [R12] Enabled CAN, wake pin, RTC, reset wake hibernate.
// [R13] Hibernate wake runs full reset sequence.
// [R14] Only regulator register survives hibernate.
// [R15] Hold-low bit keeps SDRAM CKE low on wake.
// [R16] Regulator level in 50 mV steps.
// [R17] Regulator can be disabled and bypassed.
// [R18] Sleep entry waits for PLL reconfiguration end.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module pms_sequencer (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Wake sources, asynchronous to clk
   input  wire logic        can_wake,
   input  wire logic        general_wake_pin_n,
   input  wire logic        rtc_wake,
   input  wire logic        rtc_irq,
   input  wire logic        reset_pin_n,
   // Peripheral wake requests, same clock
   input  wire logic [7:0]  periph_wake,
   // Clock and PLL control
   output logic             core_clk_en,
   output logic             sys_clk_en,
   output logic             pll_enable,
   output logic             pll_bypass,
   output logic             pll_locked,
   // Regulator and supply
   output logic             internal_core_supply_on,
   output logic             vreg_enable,
   output logic [3:0]       vreg_level,
   output logic [11:0]      vreg_mv,
   // DMA and pins
   output logic             l1_dma_allow,
   output logic             pins_hiz,
   output logic             sdram_clock_enable_pin_o,
   output logic             sdram_clock_enable_pin_oe,
   output logic             core_reset,
   output logic [5:0]       mode
);

   localparam logic [4:0] SEQ_LAST = 5'(pms_pkg::RESET_SEQ_CYCLES - 1);
   localparam logic [3:0] LOCK_LAST = 4'(pms_pkg::PLL_LOCK_CYCLES - 1);
   localparam logic [1:0] VR_FIELD_ON = 2'h3;

   // Raw asynchronous inputs pass two flip-flops first.
   logic [4:0] raw_async;
   logic [4:0] sync_async;
   logic       can_s;
   logic       gpw_low_s;
   logic       rtcw_s;
   logic       rtci_s;
   logic       rst_pin_s;

   assign raw_async = {~reset_pin_n, rtc_irq, rtc_wake, ~general_wake_pin_n, can_wake};

   pms_sync #(.W(5)) u_sync (
      .clk      (clk),
      .srst     (srst),
      .async_in (raw_async),
      .sync_out (sync_async)
   );

   assign can_s     = sync_async[0];
   assign gpw_low_s = sync_async[1];
   assign rtcw_s    = sync_async[2];
   assign rtci_s    = sync_async[3];
   assign rst_pin_s = sync_async[4];

   function automatic logic is_reg(input logic [3:0] a, input logic [3:0] idx);
      return a == idx;
   endfunction

   pms_pkg::pms_state_t state_q, state_d;
   logic [15:0] pll_q, pll_d;
   logic [15:0] vr_q, vr_d;
   logic [7:0]  mask_q, mask_d;
   logic [4:0]  seq_q, seq_d;
   logic [3:0]  lock_q, lock_d;
   logic        cke_hold_q, cke_hold_d;
   logic        req_sleep_q, req_sleep_d;
   logic        req_deep_q, req_deep_d;
   logic [15:0] rdata_q, rdata_d;
   logic        wr_pll, wr_vr, wr_mask, wr_req;
   logic        pll_dis, pll_byp, locked;
   logic        hib_wake, sleep_wake;

   assign wr_pll  = reg_wr && is_reg(reg_addr, pms_pkg::REG_PLL_CONTROL_REG);
   assign wr_vr   = reg_wr && is_reg(reg_addr, pms_pkg::REG_REGULATOR_CONTROL_REG);
   assign wr_mask = reg_wr && is_reg(reg_addr, pms_pkg::REG_WAKE_MASK);
   assign wr_req  = reg_wr && is_reg(reg_addr, pms_pkg::REG_MODE_REQ);
   assign pll_dis = pll_q[pms_pkg::PLL_DISABLE_BIT];
   assign pll_byp = pll_q[pms_pkg::PLL_BYPASS_BIT];
   assign locked  = !pll_dis && (lock_q == LOCK_LAST);

   // Each hibernate wake source except the reset pin counts only when its enable bit is set.
   assign hib_wake = rst_pin_s // [R12]
                  || (can_s     && vr_q[pms_pkg::VR_CAN_WAKE_BIT])
                  || (gpw_low_s && vr_q[pms_pkg::VR_GPW_WAKE_BIT])
                  || (rtcw_s    && vr_q[pms_pkg::VR_RTC_WAKE_BIT]);
   assign sleep_wake = |(periph_wake & mask_q); // [R07]

   always_comb begin
      state_d     = state_q;
      pll_d       = pll_q;
      vr_d        = vr_q;
      mask_d      = mask_q;
      seq_d       = seq_q;
      cke_hold_d  = cke_hold_q;
      req_sleep_d = req_sleep_q;
      req_deep_d  = req_deep_q;
      lock_d      = pll_dis ? 4'h0 : (locked ? lock_q : lock_q + 4'h1);
      if (wr_pll) begin
         pll_d = reg_wdata;
         // The PLL may only be turned off while bypassed in active mode.
         if (state_q != pms_pkg::ST_ACTIVE) begin
            pll_d[pms_pkg::PLL_DISABLE_BIT] = 1'b0; // [R03]
         end
         if (pll_d != pll_q) begin
            lock_d = 4'h0;
         end
      end
      if (wr_vr) begin
         vr_d = reg_wdata; // [R16] [R17]
      end
      if (wr_mask) begin
         mask_d = reg_wdata[7:0];
      end
      case (state_q)
         pms_pkg::ST_RESET: begin
            // Counts the reset sequence; the hold-low bit clears when it ends.
            seq_d = seq_q + 5'h1; // [R13]
            if (seq_q == SEQ_LAST) begin
               state_d    = pms_pkg::ST_FULL_ON; // [R01]
               seq_d      = 5'h0;
               cke_hold_d = 1'b0;
            end
         end
         pms_pkg::ST_FULL_ON, pms_pkg::ST_ACTIVE: begin
            if (!pll_byp && !pll_dis && state_q == pms_pkg::ST_ACTIVE) begin
               state_d = pms_pkg::ST_FULL_ON;
            end else if (pll_byp && state_q == pms_pkg::ST_FULL_ON) begin
               state_d = pms_pkg::ST_ACTIVE; // [R02]
            end
            // A request waits until the PLL has settled after any change; a deep-sleep request also goes ahead once the PLL is disabled.
            if (req_sleep_q && locked) begin // [R18] [R03]
               state_d     = pms_pkg::ST_SLEEP;
               req_sleep_d = 1'b0;
            end else if (req_deep_q && (locked || pll_dis)) begin // [R18]
               state_d    = pms_pkg::ST_DEEP_SLEEP;
               req_deep_d = 1'b0;
            end
         end
         pms_pkg::ST_SLEEP: begin
            if (sleep_wake) begin
               state_d = pll_byp ? pms_pkg::ST_ACTIVE : pms_pkg::ST_FULL_ON; // [R07]
            end
         end
         pms_pkg::ST_DEEP_SLEEP: begin
            if (rst_pin_s) begin
               // A pin reset restores the PLL and wake mask defaults, so the sequence ends in full-on.
               state_d = pms_pkg::ST_RESET; // [R09]
               seq_d   = 5'h0;
               pll_d   = pms_pkg::PLL_CONTROL_REG_RESET; // [R09]
               mask_d  = 8'h00;
               lock_d  = 4'h0;
            end else if (rtci_s) begin
               state_d = pms_pkg::ST_ACTIVE; // [R09]
               pll_d[pms_pkg::PLL_BYPASS_BIT] = 1'b1;
            end
         end
         pms_pkg::ST_HIBERNATE: begin
            if (hib_wake) begin
               state_d = pms_pkg::ST_RESET; // [R13]
               seq_d   = 5'h0;
               vr_d[pms_pkg::VR_FIELD_A_LSB +: 2] = VR_FIELD_ON;
            end
         end
         default: state_d = pms_pkg::ST_RESET;
      endcase
      // Taken after the state decode so a request written in the cycle that
      // consumes the previous one is not lost.
      if (wr_req) begin
         req_sleep_d = reg_wdata[1:0] == pms_pkg::REQ_SLEEP;
         req_deep_d  = reg_wdata[1:0] == pms_pkg::REQ_DEEP_SLEEP;
      end
      // Field A written to zero shuts the regulator off from any running state.
      if (wr_vr && reg_wdata[pms_pkg::VR_FIELD_A_LSB +: 2] == pms_pkg::VR_FIELD_A_OFF
          && state_q != pms_pkg::ST_RESET) begin
         state_d     = pms_pkg::ST_HIBERNATE; // [R10]
         cke_hold_d  = reg_wdata[pms_pkg::VR_CKELOW_BIT]; // [R15]
         // Everything except the regulator register is lost.
         pll_d       = pms_pkg::PLL_CONTROL_REG_RESET; // [R14]
         mask_d      = 8'h00;
         req_sleep_d = 1'b0;
         req_deep_d  = 1'b0;
      end
      if (state_q == pms_pkg::ST_HIBERNATE && hib_wake) begin
         pll_d  = pms_pkg::PLL_CONTROL_REG_RESET; // [R14]
         mask_d = 8'h00;
         lock_d = 4'h0;
      end
      rdata_d = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            pms_pkg::REG_PLL_CONTROL_REG:   rdata_d = pll_q;
            pms_pkg::REG_REGULATOR_CONTROL_REG:    rdata_d = vr_q;
            pms_pkg::REG_WAKE_MASK: rdata_d = {8'h00, mask_q};
            pms_pkg::REG_MODE_REQ:  rdata_d = {14'h0000, req_deep_q, req_sleep_q};
            pms_pkg::REG_STATUS:    rdata_d = {9'h000, locked, state_q};
            default:                rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q     <= pms_pkg::ST_RESET;
         pll_q       <= pms_pkg::PLL_CONTROL_REG_RESET;
         vr_q        <= pms_pkg::REGULATOR_CONTROL_REG_RESET;
         mask_q      <= 8'h00;
         seq_q       <= 5'h0;
         lock_q      <= 4'h0;
         cke_hold_q  <= 1'b0;
         req_sleep_q <= 1'b0;
         req_deep_q  <= 1'b0;
         rdata_q     <= 16'h0000;
      end else begin
         state_q     <= state_d;
         pll_q       <= pll_d;
         vr_q        <= vr_d;
         mask_q      <= mask_d;
         seq_q       <= seq_d;
         lock_q      <= lock_d;
         cke_hold_q  <= cke_hold_d;
         req_sleep_q <= req_sleep_d;
         req_deep_q  <= req_deep_d;
         rdata_q     <= rdata_d;
      end
   end

   logic running;
   assign running = (state_q == pms_pkg::ST_FULL_ON) || (state_q == pms_pkg::ST_ACTIVE);

   assign reg_rdata   = rdata_q;
   assign mode        = state_q;
   assign core_clk_en = running; // [R05] [R08]
   assign sys_clk_en  = running || (state_q == pms_pkg::ST_SLEEP); // [R05] [R08] [R10]
   assign pll_enable  = !pll_dis && (running || state_q == pms_pkg::ST_SLEEP
                        || state_q == pms_pkg::ST_RESET); // [R01] [R08]
   assign pll_bypass  = state_q == pms_pkg::ST_ACTIVE; // [R02]
   assign pll_locked  = locked;
   assign l1_dma_allow = running; // [R04] [R06]
   assign internal_core_supply_on = state_q != pms_pkg::ST_HIBERNATE; // [R10]
   assign vreg_enable = !vr_q[pms_pkg::VR_BYPASS_BIT]
                        && state_q != pms_pkg::ST_HIBERNATE; // [R17]
   assign vreg_level  = vr_q[pms_pkg::VR_LEVEL_LSB +: 4];
   assign vreg_mv     = 12'(pms_pkg::VR_BASE_MV)
                        + 12'(vreg_level) * 12'(pms_pkg::VR_STEP_MV); // [R16]
   assign pins_hiz    = state_q == pms_pkg::ST_HIBERNATE; // [R11]
   assign core_reset  = state_q == pms_pkg::ST_RESET; // [R13]
   // CKE pin released while hibernating; the board pull-down then holds it low.
   assign sdram_clock_enable_pin_oe = !pins_hiz; // [R11]
   assign sdram_clock_enable_pin_o  = !(cke_hold_q || core_reset); // [R15]

endmodule

// ### tb/pms_sequencer_monitor.sv
// Assertion checker bound to the power-mode sequencer.
`timescale 1ns/1ps
module pms_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // Watched outputs
   input wire logic        core_clk_en,
   input wire logic        sys_clk_en,
   input wire logic        pll_enable,
   input wire logic        pll_bypass,
   input wire logic        internal_core_supply_on,
   input wire logic [3:0]  vreg_level,
   input wire logic [11:0] vreg_mv,
   input wire logic        l1_dma_allow,
   input wire logic        pins_hiz,
   input wire logic        sdram_clock_enable_pin_o,
   input wire logic        sdram_clock_enable_pin_oe,
   input wire logic        core_reset,
   input wire logic [5:0]  mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // Mode is one-hot: 01 reset, 02 full-on, 04 active, 08 sleep, 10 deep sleep, 20 hibernate.
   property p_full;
      mode == 6'h02 |-> pll_enable && !pll_bypass && core_clk_en && sys_clk_en;
   endproperty
   a_full: assert property (p_full) else $error("full-on setting wrong");
   property p_active;
      mode == 6'h04 |-> pll_bypass && core_clk_en && sys_clk_en && l1_dma_allow;
   endproperty
   a_active: assert property (p_active) else $error("active setting wrong");
   property p_sleep;
      mode == 6'h08 |-> !core_clk_en && sys_clk_en && pll_enable && !l1_dma_allow;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep setting wrong");
   property p_deep;
      mode == 6'h10 |-> !core_clk_en && !sys_clk_en;
   endproperty
   a_deep: assert property (p_deep) else $error("deep sleep clocks run");
   property p_hib;
      mode == 6'h20 |-> !internal_core_supply_on && pins_hiz && !sdram_clock_enable_pin_oe;
   endproperty
   a_hib: assert property (p_hib) else $error("hibernate pins or supply wrong");
   property p_mv;
      vreg_mv == 12'(700 + 50 * vreg_level);
   endproperty
   a_mv: assert property (p_mv) else $error("regulator millivolts wrong");
   property p_rst_seq;
      mode == 6'h01 |-> core_reset && !sdram_clock_enable_pin_o;
   endproperty
   a_rst_seq: assert property (p_rst_seq) else $error("reset outputs wrong");
   property p_hib_exit;
      (mode == 6'h20) ##1 (mode != 6'h20) |-> mode == 6'h01;
   endproperty
   a_hib_exit: assert property (p_hib_exit) else $error("hibernate left without reset");
   c_sleep_wake: cover property ((mode == 6'h08) ##1 (mode == 6'h04));
   c_deep_rtc: cover property ((mode == 6'h10) ##[1:8] (mode == 6'h04));
   c_hib_wake: cover property ((mode == 6'h20) ##1 (mode == 6'h01));
endmodule

bind pms_sequencer pms_monitor u_mon (.*);

// ### tb/pms_wake_model.sv
// Model of the wake sources, RTC and reset pin outside the sequencer.
`timescale 1ns/1ps
module pms_wake_model (
   // Timing clock
   input wire logic clk,
   // Wake levels
   output logic     can_wake,
   output logic     general_wake_pin_n,
   output logic     rtc_wake,
   output logic     rtc_irq,
   output logic     reset_pin_n
);
   logic [4:0] src_q = 5'h00;
   // The wake pin rests high on its pull-up and the reset pin rests released.
   assign can_wake           = src_q[0];
   assign general_wake_pin_n = ~src_q[1];
   assign rtc_wake           = src_q[2];
   assign rtc_irq            = src_q[3];
   assign reset_pin_n        = ~src_q[4];
   // A level held under one cycle may be lost in the two-stage synchroniser.
   task automatic fire(input int idx, input int len);
      @(posedge clk);
      src_q[idx] <= 1'b1;
      repeat (len) @(posedge clk);
      src_q[idx] <= 1'b0;
   endtask
endmodule

// ### tb/power_mode_sequencer_test.sv
// Self-checking testbench of the power-mode sequencer.
`timescale 1ns/1ps
module power_mode_sequencer_test;
   logic        clk, srst, reg_wr, reg_rd;
   logic [3:0]  reg_addr, vreg_level;
   logic [15:0] reg_wdata, reg_rdata;
   logic [7:0]  periph_wake;
   logic        can_wake, general_wake_pin_n, rtc_wake, rtc_irq, reset_pin_n;
   logic        core_clk_en, sys_clk_en, pll_enable, pll_bypass, pll_locked, vreg_enable;
   logic        internal_core_supply_on, l1_dma_allow, pins_hiz, core_reset;
   logic        sdram_clock_enable_pin_o, sdram_clock_enable_pin_oe;
   logic [11:0] vreg_mv;
   logic [5:0]  mode;
   int          failures, check_count, cycles;
   pms_sequencer u_dut (.*);
   pms_wake_model u_wake (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic ck(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 ck(reg_rdata, exp, "read");
   endtask
   task automatic pw(input logic [7:0] m);
      @(posedge clk);
      periph_wake <= m;
      @(posedge clk);
      periph_wake <= 8'h00;
   endtask
   task automatic wm(input logic [5:0] m);
      int n = 0;
      #1;
      while (mode !== m && n < 80) begin
         @(posedge clk);
         #1 n++;
      end
      ck(mode, m, "mode");
   endtask
   // A refused event must leave the mode alone well past the synchroniser delay.
   task automatic stay(input logic [5:0] m);
      repeat (10) @(posedge clk);
      #1 ck(mode, m, "held mode");
   endtask
   task automatic t_up();
      ck(core_reset, 1'b1, "reset seq");
      wm(6'h02);
      ck({pll_enable, pll_bypass, core_clk_en, sys_clk_en}, 4'hB, "full-on");
      ck(pll_locked, 1'b1, "locked");
      ck(vreg_mv, 12'h4E2, "mv");
      rd(4'h0, pms_pkg::PLL_CONTROL_REG_RESET);
      rd(4'h1, pms_pkg::REGULATOR_CONTROL_REG_RESET);
      rd(4'hF, 16'h0000);
      wr(4'h1, 16'h1053);
      #1 ck({vreg_enable, vreg_level}, 5'h05, "bypassed");
      ck(vreg_mv, 12'h3B6, "mv");
      wr(4'h1, 16'h40B3);
      #1 ck(vreg_enable, 1'b1, "regulator on");
      rd(4'h4, 16'h0042);
      $display("power-up test done");
   endtask
   task automatic t_sleep();
      wr(4'h0, 16'h0100);
      wr(4'h2, 16'h0001);
      wr(4'h3, 16'h0001);
      wm(6'h08);
      ck({core_clk_en, sys_clk_en, pll_enable, l1_dma_allow}, 4'h6, "sleep");
      pw(8'h02);
      stay(6'h08);
      pw(8'h01);
      wm(6'h04);
      ck({pll_bypass, core_clk_en, sys_clk_en, l1_dma_allow}, 4'hF, "active");
      wr(4'h0, 16'h0101);
      rd(4'h0, 16'h0101);
      ck(pll_locked, 1'b0, "unlocked");
      wr(4'h3, 16'h0001);
      stay(6'h04);
      wr(4'h0, 16'h0000);
      wr(4'h3, 16'h0001);
      wm(6'h08);
      pw(8'h01);
      wm(6'h02);
      wr(4'h0, 16'h0001);
      rd(4'h0, 16'h0000);
      $display("sleep test done");
   endtask
   task automatic t_deep();
      wr(4'h3, 16'h0002);
      wm(6'h10);
      ck({core_clk_en, sys_clk_en}, 2'h0, "deep");
      pw(8'h01);
      stay(6'h10);
      u_wake.fire(3, 4);
      wm(6'h04);
      wr(4'h3, 16'h0002);
      wm(6'h10);
      u_wake.fire(4, 4);
      wm(6'h01);
      wm(6'h02);
      stay(6'h02);
      rd(4'h0, 16'h0000);
      $display("deep sleep test done");
   endtask
   task automatic t_hib();
      logic [15:0] en [4] = '{16'h0200, 16'h0100, 16'h0400, 16'h0000};
      int          src [4] = '{1, 0, 2, 4};
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, 16'h0100);
         wr(4'h2, 16'h0001);
         wr(4'h1, 16'hC0B0 | en[i]);
         wm(6'h20);
         ck({internal_core_supply_on, pins_hiz, sdram_clock_enable_pin_oe}, 3'h2, "hib");
         if (i == 0) begin
            u_wake.fire(0, 4);
            stay(6'h20);
         end
         u_wake.fire(src[i], 4);
         wm(6'h01);
         ck(sdram_clock_enable_pin_o, 1'b0, "cke");
         wm(6'h02);
         rd(4'h0, 16'h0000);
         rd(4'h2, 16'h0000);
         rd(4'h1, 16'hC0B3 | en[i]);
      end
      $display("hibernate test done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      srst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      periph_wake = 8'h00;
      cycles = 0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_up();
      t_sleep();
      t_deep();
      t_hib();
      wrap_up();
   end
endmodule
